// File: hdl/pfa_pkg.sv
/*
 * shared constants and types for the protection fet and alert control block.
 * assumes a 100 MHz pclk and an apb master with 32-bit data.
 */
package pfa_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] AUTO_OFF = 8'h04;
    localparam logic [7:0] BDTH_OFF = 8'h08;
    localparam logic [7:0] DPWM_OFF = 8'h0C;
    localparam logic [7:0] CPWM_OFF = 8'h10;
    localparam logic [7:0] MASK_OFF = 8'h14;
    localparam logic [7:0] LATCH_OFF = 8'h18;
    localparam logic [7:0] RAW_OFF = 8'h1C;
    localparam logic [7:0] STAT_OFF = 8'h20;
    localparam logic [7:0] RLIM_OFF = 8'h24;

    // control register fields
    localparam int C_SERIES = 0;
    localparam int C_BDP_EN = 1;
    localparam int C_MANUAL = 2;
    localparam int C_FORCE_OK = 3;
    localparam int C_DSG_BLOCK = 4;
    localparam int C_CHG_BLOCK = 5;
    localparam int C_DSG_FORCE = 6;
    localparam int C_CHG_FORCE = 7;
    localparam int C_DSG_PWM = 8;
    localparam int C_CHG_PWM = 9;
    localparam int C_REG_EN = 10;
    localparam int C_OT_SHDN = 11;
    localparam int C_REF_DIAG = 12;
    localparam int C_VSEL_LO = 13;

    // flag positions
    localparam int CELL_LOW_VOLTAGE_FAULT = 0;
    localparam int CELL_HIGH_VOLTAGE_FAULT = 1;
    localparam int DISCHARGE_HOT_FAULT = 2;
    localparam int DISCHARGE_COLD_FAULT = 3;
    localparam int DISCHARGE_CURRENT_FAULT_1 = 4;
    localparam int DISCHARGE_CURRENT_FAULT_2 = 5;
    localparam int SHORT_CIRCUIT_FAULT = 6;
    localparam int CHARGE_HOT_FAULT = 7;
    localparam int CHARGE_COLD_FAULT = 8;
    localparam int CHARGE_CURRENT_FAULT = 9;
    localparam int REF_DIAG_FAULT = 10;
    localparam int DIE_HOT_FLAG = 11;

    typedef logic [9:0] pfa_fault_t;
    typedef logic [11:0] pfa_flag_t;

    localparam pfa_flag_t DSG_GROUP = 12'h47D;
    localparam pfa_flag_t CHG_GROUP = 12'h7C2;

    // reset values
    localparam logic [15:0] CTRL_RST = 16'h1000;
    localparam pfa_flag_t AUTO_RST = 12'h7FF;
    localparam pfa_flag_t MASK_RST = 12'hFFF;
    localparam logic [15:0] BDTH_RST = 16'h0064;
    localparam logic [31:0] PWM_RST = 32'h0064_0064;
    localparam logic [31:0] RLIM_RST = 32'h07D0_06A4;

    // regulator voltage codes
    localparam logic [2:0] VSEL_1V8 = 3'h0;
    localparam logic [2:0] VSEL_2V5 = 3'h1;
    localparam logic [2:0] VSEL_3V0 = 3'h2;
    localparam logic [2:0] VSEL_3V3 = 3'h3;
    localparam logic [2:0] VSEL_5V0 = 3'h4;

    // charge pin active pull-low time
    localparam int CLK_MHZ = 100;
    localparam int CHG_PULL_US = 100;
    localparam int CHG_PULL_CYC = CHG_PULL_US * CLK_MHZ;
    localparam int PULL_W = 14;

    typedef struct packed {
        logic [15:0] off_cyc;
        logic [15:0] on_cyc;
    } pfa_pwm_s;

    typedef enum logic [2:0] {
        CHG_OFF = 3'b001,
        CHG_ON = 3'b010,
        CHG_PULL = 3'b100
    } pfa_chg_e;

    // any flag present within a group
    function automatic logic pfa_any(input pfa_flag_t f, input pfa_flag_t m);
        return |(f & m);
    endfunction : pfa_any

    // invalid voltage codes fall back to the lowest output
    function automatic logic [2:0] pfa_vsel(input logic [2:0] v);
        return (v > VSEL_5V0) ? VSEL_1V8 : v;
    endfunction : pfa_vsel
endpackage : pfa_pkg

// File: hdl/pfa_sync.sv
/*
 * two-flop synchroniser for asynchronous levels.
 * assumes the destination clock is pclk.
 */
`timescale 1ns/10ps
module pfa_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } pfa_sync_s;

    pfa_sync_s st_ff;
    pfa_sync_s nxt_st;

    // first stage feeds only the second
    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;
endmodule : pfa_sync

// File: hdl/pfa_pwm.sv
/*
 * on/off gate for one fet driver in pwm mode.
 * assumes periods counted in pclk cycles; gate stays high when disabled.
 */
`timescale 1ns/10ps
module pfa_pwm (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire pfa_pkg::pfa_pwm_s cfg,
    output logic gate
);
    typedef struct packed {
        logic on_ph;
        logic [15:0] cnt;
    } pfa_pwm_st_s;

    pfa_pwm_st_s st_ff;
    pfa_pwm_st_s nxt_st;

    // zero off time means the gate never opens
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cnt = st_ff.cnt + 16'h0001;
        if (!en) begin
            nxt_st.on_ph = 1'b1;
            nxt_st.cnt = 16'h0000;
        end else if (st_ff.on_ph && st_ff.cnt + 16'h0001 >= cfg.on_cyc && cfg.off_cyc != 16'h0000) begin
            nxt_st.on_ph = 1'b0;
            nxt_st.cnt = 16'h0000;
        end else if (!st_ff.on_ph && st_ff.cnt + 16'h0001 >= cfg.off_cyc) begin
            nxt_st.on_ph = 1'b1;
            nxt_st.cnt = 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{on_ph: 1'b1, cnt: 16'h0000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign gate = st_ff.on_ph;
endmodule : pfa_pwm

// File: hdl/pfa_top.sv
/*
 * fet driver decisions, body-diode protection, pwm gating, alarm latch
 * and external regulator enable, with an apb register slave.
 * assumes fault inputs come from same-clock protection logic, while
 * charger_present and die_hot arrive asynchronously.
 */
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// - discharge drive high only when unblocked and fault-free, or for body-diode protection
// - charge drive high only when unblocked and fault-free, or for body-diode protection
// - force-on commands act only when forcing is permitted by configuration
// - series with diode protection: discharge driver on while charging under discharge fault
// - series with diode protection: charge driver on while discharging under charge fault
// - charging or discharging judged by absolute current against programmable threshold
// - discharge off drives low and disables discharge overcurrent protections
// - charge driver off leaves overcurrent protections untouched
// - charge driver off pulls low about 100us, then releases the pin
// - both drivers offer pwm switching to limit average current
// - charge pwm only without charger; discharge pwm switches continually
// - per-protection settings choose autonomous control of the fet drivers
// - out-of-range core regulator reading raises a diagnostic fault when enabled
// - regulator stays off or enables itself on every exit from shutdown
// - regulator voltage selectable among 1.8, 2.5, 3.0, 3.3 and 5.0 volts
// - die over-temperature disables regulator and optionally requests shutdown
// - regulator returns by itself once die cools without shutdown
// - manual host mode only flags faults; host turns fets off
// - alarm pin pulled low whenever an alarm is raised
// - writable mask selects which flags may raise the alarm
// - selected flags stay latched until host clears them
// - instantaneous flags readable beside latched flags
module pfa_top #(
    parameter int unsigned CHG_PULL_CYCLES = pfa_pkg::CHG_PULL_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pfa_pkg::pfa_fault_t fault_raw,
    input wire logic signed [15:0] cc_current,
    input wire logic [15:0] core_reg_mv,
    input wire logic core_reg_valid,
    input wire logic charger_present,
    input wire logic die_hot,
    input wire logic strap_reg_auto,
    input wire logic [2:0] strap_reg_vsel,
    output logic discharge_fet_drive,
    output logic charge_fet_drive,
    output logic charge_pull_low,
    output logic dsg_ocp_enable,
    output logic external_supply_regulator,
    output logic [2:0] regulator_vsel,
    output logic shutdown_req,
    output logic alert_o,
    output logic alert_oe
);
    typedef struct packed {
        logic loaded;
        logic [15:0] ctrl;
        pfa_pkg::pfa_flag_t auto_en;
        logic [15:0] bdth;
        pfa_pkg::pfa_pwm_s dpwm;
        pfa_pkg::pfa_pwm_s cpwm;
        pfa_pkg::pfa_flag_t mask;
        pfa_pkg::pfa_flag_t latch;
        logic [31:0] rlim;
        logic ref_bad;
        logic dsg_on;
        logic chg_on;
        pfa_pkg::pfa_chg_e chg_st;
        logic [pfa_pkg::PULL_W-1:0] pull_cnt;
        logic reg_en;
        logic shdn;
        logic alert;
        logic [31:0] prdata;
    } pfa_top_s;

    localparam logic [pfa_pkg::PULL_W-1:0] PULL_LAST = pfa_pkg::PULL_W'(CHG_PULL_CYCLES - 1);

    pfa_top_s st_ff;
    pfa_top_s nxt_st;

    logic chg_seen;
    logic hot_seen;
    logic dsg_gate;
    logic chg_gate;
    logic [15:0] cur_abs;
    logic charging;
    logic discharging;
    pfa_pkg::pfa_flag_t flags;
    pfa_pkg::pfa_flag_t autoc;
    logic dsg_fault;
    logic chg_fault;
    logic dsg_allow;
    logic chg_allow;
    logic dsg_pwm_on;
    logic chg_pwm_on;
    logic wr_acc;
    logic addr_ok;
    logic [31:0] rd_val;

    // asynchronous pin levels
    pfa_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({charger_present, die_hot}),
        .q({chg_seen, hot_seen})
    );

    // period counters, one per driver
    pfa_pwm u_dpwm (
        .pclk(pclk),
        .presetn(presetn),
        .en(dsg_pwm_on),
        .cfg(st_ff.dpwm),
        .gate(dsg_gate)
    );

    pfa_pwm u_cpwm (
        .pclk(pclk),
        .presetn(presetn),
        .en(chg_pwm_on),
        .cfg(st_ff.cpwm),
        .gate(chg_gate)
    );

    // current direction from the coulomb counter sign and magnitude
    assign cur_abs = cc_current[15] ? 16'(-cc_current) : cc_current;
    assign charging = !cc_current[15] && cur_abs > st_ff.bdth;
    assign discharging = cc_current[15] && cur_abs > st_ff.bdth;

    // full flag set: external faults plus internal diagnostics
    assign flags = {hot_seen,
                    st_ff.ref_bad && st_ff.ctrl[pfa_pkg::C_REF_DIAG],
                    fault_raw};

    // manual host mode drops all autonomous fet control
    assign autoc = st_ff.ctrl[pfa_pkg::C_MANUAL] ? '0 : st_ff.auto_en;
    assign dsg_fault = pfa_pkg::pfa_any(flags & autoc, pfa_pkg::DSG_GROUP);
    assign chg_fault = pfa_pkg::pfa_any(flags & autoc, pfa_pkg::CHG_GROUP);

    // driver decisions; force bypasses blocking and faults
    always_comb begin
        dsg_allow = !st_ff.ctrl[pfa_pkg::C_DSG_BLOCK] && !dsg_fault;
        chg_allow = !st_ff.ctrl[pfa_pkg::C_CHG_BLOCK] && !chg_fault;
        if (st_ff.ctrl[pfa_pkg::C_FORCE_OK] && st_ff.ctrl[pfa_pkg::C_DSG_FORCE]) begin
            dsg_allow = 1'b1;
        end
        if (st_ff.ctrl[pfa_pkg::C_FORCE_OK] && st_ff.ctrl[pfa_pkg::C_CHG_FORCE]) begin
            chg_allow = 1'b1;
        end
        if (st_ff.ctrl[pfa_pkg::C_SERIES] && st_ff.ctrl[pfa_pkg::C_BDP_EN]) begin
            if (charging && dsg_fault) begin
                dsg_allow = 1'b1;
            end
            if (discharging && chg_fault) begin
                chg_allow = 1'b1;
            end
        end
    end

    // a charger would hold the gate low slowly, so no charge pwm then
    assign dsg_pwm_on = st_ff.ctrl[pfa_pkg::C_DSG_PWM] && dsg_allow;
    assign chg_pwm_on = st_ff.ctrl[pfa_pkg::C_CHG_PWM] && chg_allow && !chg_seen;

    // apb decode; slave never waits
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // read mux
    always_comb begin
        addr_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            pfa_pkg::CTRL_OFF: rd_val = {16'h0000, st_ff.ctrl};
            pfa_pkg::AUTO_OFF: rd_val = {20'h00000, st_ff.auto_en};
            pfa_pkg::BDTH_OFF: rd_val = {16'h0000, st_ff.bdth};
            pfa_pkg::DPWM_OFF: rd_val = st_ff.dpwm;
            pfa_pkg::CPWM_OFF: rd_val = st_ff.cpwm;
            pfa_pkg::MASK_OFF: rd_val = {20'h00000, st_ff.mask};
            pfa_pkg::LATCH_OFF: rd_val = {20'h00000, st_ff.latch};
            pfa_pkg::RAW_OFF: rd_val = {20'h00000, flags};
            pfa_pkg::STAT_OFF: rd_val = {22'h000000, st_ff.alert, st_ff.shdn, st_ff.reg_en,
                                         st_ff.chg_st == pfa_pkg::CHG_PULL, st_ff.chg_on,
                                         st_ff.dsg_on, chg_seen, discharging, charging,
                                         st_ff.ref_bad};
            pfa_pkg::RLIM_OFF: rd_val = st_ff.rlim;
            default: addr_ok = 1'b0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        nxt_st = st_ff;

        // read data captured in the setup cycle
        if (psel && !penable) begin
            nxt_st.prdata = rd_val;
        end

        // register writes at the access edge
        if (wr_acc) begin
            case (paddr)
                pfa_pkg::CTRL_OFF: nxt_st.ctrl = pwdata[15:0];
                pfa_pkg::AUTO_OFF: nxt_st.auto_en = pwdata[11:0];
                pfa_pkg::BDTH_OFF: nxt_st.bdth = pwdata[15:0];
                pfa_pkg::DPWM_OFF: nxt_st.dpwm = pwdata;
                pfa_pkg::CPWM_OFF: nxt_st.cpwm = pwdata;
                pfa_pkg::MASK_OFF: nxt_st.mask = pwdata[11:0];
                pfa_pkg::LATCH_OFF: nxt_st.latch = st_ff.latch & ~pwdata[11:0];
                pfa_pkg::RLIM_OFF: nxt_st.rlim = pwdata;
                default: nxt_st.prdata = st_ff.prdata;
            endcase
        end

        // first cycle after reset release: stored regulator setup
        if (!st_ff.loaded) begin
            nxt_st.loaded = 1'b1;
            nxt_st.ctrl[pfa_pkg::C_REG_EN] = strap_reg_auto;
            nxt_st.ctrl[pfa_pkg::C_VSEL_LO +: 3] = strap_reg_vsel;
        end

        // core regulator range check, held until next reading
        if (core_reg_valid) begin
            nxt_st.ref_bad = core_reg_mv < st_ff.rlim[15:0] || core_reg_mv > st_ff.rlim[31:16];
        end

        // latch selected flags; a new event beats a same-cycle clear
        nxt_st.latch = nxt_st.latch | (flags & st_ff.mask);
        nxt_st.alert = pfa_pkg::pfa_any(nxt_st.latch, st_ff.mask);

        // drivers follow allow, chopped by the pwm gate when active
        nxt_st.dsg_on = dsg_allow && (dsg_gate || !dsg_pwm_on);
        nxt_st.chg_on = chg_allow && (chg_gate || !chg_pwm_on);

        // charge pin: high, timed pull-low, then released
        case (st_ff.chg_st)
            pfa_pkg::CHG_OFF: begin
                if (nxt_st.chg_on) begin
                    nxt_st.chg_st = pfa_pkg::CHG_ON;
                end
            end
            pfa_pkg::CHG_ON: begin
                if (!nxt_st.chg_on) begin
                    nxt_st.chg_st = pfa_pkg::CHG_PULL;
                    nxt_st.pull_cnt = '0;
                end
            end
            pfa_pkg::CHG_PULL: begin
                nxt_st.pull_cnt = st_ff.pull_cnt + 1'b1;
                if (nxt_st.chg_on) begin
                    nxt_st.chg_st = pfa_pkg::CHG_ON;
                end else if (st_ff.pull_cnt >= PULL_LAST) begin
                    nxt_st.chg_st = pfa_pkg::CHG_OFF;
                end
            end
            default: nxt_st.chg_st = pfa_pkg::CHG_OFF;
        endcase

        // regulator: configured enable gated by die temperature
        nxt_st.reg_en = nxt_st.ctrl[pfa_pkg::C_REG_EN] && !hot_seen && !st_ff.shdn;
        if (hot_seen && st_ff.ctrl[pfa_pkg::C_OT_SHDN]) begin
            nxt_st.shdn = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{loaded: 1'b0,
                       ctrl: pfa_pkg::CTRL_RST,
                       auto_en: pfa_pkg::AUTO_RST,
                       bdth: pfa_pkg::BDTH_RST,
                       dpwm: pfa_pkg::PWM_RST,
                       cpwm: pfa_pkg::PWM_RST,
                       mask: pfa_pkg::MASK_RST,
                       latch: 12'h000,
                       rlim: pfa_pkg::RLIM_RST,
                       ref_bad: 1'b0,
                       dsg_on: 1'b0,
                       chg_on: 1'b0,
                       chg_st: pfa_pkg::CHG_OFF,
                       pull_cnt: '0,
                       reg_en: 1'b0,
                       shdn: 1'b0,
                       alert: 1'b0,
                       prdata: 32'h0000_0000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from state
    assign prdata = st_ff.prdata;
    assign discharge_fet_drive = st_ff.dsg_on;
    assign dsg_ocp_enable = st_ff.dsg_on;
    assign charge_fet_drive = st_ff.chg_st == pfa_pkg::CHG_ON;
    assign charge_pull_low = st_ff.chg_st == pfa_pkg::CHG_PULL;
    assign external_supply_regulator = st_ff.reg_en;
    assign regulator_vsel = pfa_pkg::pfa_vsel(st_ff.ctrl[pfa_pkg::C_VSEL_LO +: 3]);
    assign shutdown_req = st_ff.shdn;
    assign alert_o = 1'b0; // open drain: only ever pulls low
    assign alert_oe = st_ff.alert;
endmodule : pfa_top

// File: tb/pfa_fet_model.sv
/*
 * far-side model: protection nfet gates and the host's pulled-up alarm line.
 * assumes the alarm line has a pull-up and the charge gate a pull-down resistor.
 */
`timescale 1ns/10ps
module pfa_fet_model (
    input wire logic alert_oe,
    input wire logic alert_o,
    input wire logic charge_fet_drive,
    input wire logic charge_pull_low,
    input wire logic discharge_fet_drive,
    output logic alert_n,
    output logic chg_gate,
    output logic dsg_gate
);
    // released pin floats up through the host pull-up
    assign alert_n = alert_oe ? alert_o : 1'b1;
    // gate resistor settles charge gate low once the pull ends
    assign chg_gate = charge_fet_drive & ~charge_pull_low;
    assign dsg_gate = discharge_fet_drive;
endmodule : pfa_fet_model

// File: tb/pfa_top_checker.sv
/*
 * port-level assertions for the fet and alarm block.
 * assumes one pclk domain with asynchronous active-low presetn.
 */
`timescale 1ns/10ps
module pfa_top_checker #(
    parameter int unsigned CHG_PULL_CYCLES = 10000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic die_hot,
    input wire logic discharge_fet_drive,
    input wire logic charge_fet_drive,
    input wire logic charge_pull_low,
    input wire logic dsg_ocp_enable,
    input wire logic external_supply_regulator,
    input wire logic [2:0] regulator_vsel,
    input wire logic shutdown_req,
    input wire logic alert_o
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int unsigned pcnt;
    // length of the current active pull-low stretch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pcnt <= 0;
        else pcnt <= charge_pull_low ? pcnt + 1 : 0;
    end
    ocp_follow_a: assert property (dsg_ocp_enable == discharge_fet_drive)
        else $error("overcurrent enable differs from discharge drive");
    pull_start_a: assert property ($fell(charge_fet_drive) |-> charge_pull_low)
        else $error("no pull-low after charge turn-off");
    pull_end_a: assert property ($fell(charge_pull_low) && !charge_fet_drive |-> pcnt == CHG_PULL_CYCLES)
        else $error("pull-low stretch has wrong length");
    pull_excl_a: assert property (charge_pull_low |-> !charge_fet_drive)
        else $error("pull-low while driving high");
    reg_hot_a: assert property (die_hot [*4] |-> !external_supply_regulator)
        else $error("regulator on while die hot");
    shdn_hold_a: assert property ($rose(shutdown_req) |=> shutdown_req [*8])
        else $error("shutdown request dropped");
    vsel_range_a: assert property (regulator_vsel <= 3'h4)
        else $error("regulator code out of range");
    alarm_od_a: assert property (alert_o == 1'b0)
        else $error("alarm pin driven high");
    bus_ready_a: assert property (psel && penable |-> pready)
        else $error("access without ready");
    bus_err_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
        else $error("unmapped access without error");
endmodule : pfa_top_checker

bind pfa_top pfa_top_checker #(.CHG_PULL_CYCLES(CHG_PULL_CYCLES)) chk_u (.pclk, .presetn, .psel, .penable,
    .paddr, .pready, .pslverr, .die_hot, .discharge_fet_drive, .charge_fet_drive, .charge_pull_low,
    .dsg_ocp_enable, .external_supply_regulator, .regulator_vsel, .shutdown_req, .alert_o);

// File: tb/protection_fet_alert_control_tb_top.sv
/*
 * directed bench: apb register tasks plus fault, current and temperature stimulus.
 * assumes zero-wait apb slave and a 20-cycle pull-low parameter.
 */
`timescale 1ns/10ps
module protection_fet_alert_control_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    pfa_pkg::pfa_fault_t fault_raw;
    logic signed [15:0] cc_current;
    logic [15:0] core_reg_mv;
    logic core_reg_valid, charger_present, die_hot, strap_reg_auto;
    logic [2:0] strap_reg_vsel, regulator_vsel;
    logic discharge_fet_drive, charge_fet_drive, charge_pull_low, dsg_ocp_enable;
    logic external_supply_regulator, shutdown_req, alert_o, alert_oe, alert_n;
    int err_count, num_checks, i, n;

    pfa_top #(.CHG_PULL_CYCLES(20)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fault_raw, .cc_current, .core_reg_mv, .core_reg_valid, .charger_present,
        .die_hot, .strap_reg_auto, .strap_reg_vsel, .discharge_fet_drive, .charge_fet_drive, .charge_pull_low,
        .dsg_ocp_enable, .external_supply_regulator, .regulator_vsel, .shutdown_req, .alert_o, .alert_oe);
    pfa_fet_model fet_u (.alert_oe, .alert_o, .charge_fet_drive, .charge_pull_low, .discharge_fet_drive,
        .alert_n, .chg_gate(), .dsg_gate());

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until ready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_count++;
            end_of_test();
        end
        rdv = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask : rd

    // settle past the edge so registered outputs have landed
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask : cyc

    task automatic fl(input logic [9:0] v, input logic signed [15:0] c);
        @(posedge pclk);
        fault_raw <= v;
        cc_current <= c;
        cyc(3);
    endtask : fl

    task automatic pulse(input logic [15:0] mv);
        @(posedge pclk);
        core_reg_mv <= mv;
        core_reg_valid <= 1'b1;
        @(posedge pclk);
        core_reg_valid <= 1'b0;
        cyc(3);
    endtask : pulse

    // counts high cycles of one driver over ten pwm periods
    task automatic pw(input bit c);
        n = 0;
        repeat (70) begin
            @(posedge pclk);
            #1;
            n += c ? charge_fet_drive : discharge_fet_drive;
        end
    endtask : pw

    initial begin
        {psel, penable, pwrite, paddr, pwdata, fault_raw, cc_current} = '0;
        {core_reg_valid, charger_present, die_hot} = '0;
        core_reg_mv = 16'h0700;
        strap_reg_auto = 1'b1;
        strap_reg_vsel = 3'h3;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        cyc(3);
        chk({external_supply_regulator, regulator_vsel}, 4'hB);
        rd(8'h00, 32'h7400);
        rd(8'h04, 32'h7FF);
        rd(8'h0C, 32'h0064_0064);
        rd(8'h14, 32'hFFF);
        rd(8'h40, 32'h0);
        chk(se, 1'b1);
        // discharge fault: latched alarm until cleared
        fl(10'h001, 16'sh0000);
        chk({discharge_fet_drive, dsg_ocp_enable, charge_fet_drive, alert_n}, 4'h2);
        rd(8'h1C, 32'h1);
        fl(10'h000, 16'sh0000);
        chk({alert_n, discharge_fet_drive, dsg_ocp_enable}, 3'h3);
        rd(8'h18, 32'h1);
        wr(8'h18, 32'hFFF);
        cyc(3);
        chk(alert_n, 1'b1);
        // charge fault: pull-low stretch, discharge side untouched
        fl(10'h002, 16'sh0000);
        chk({charge_fet_drive, charge_pull_low, dsg_ocp_enable}, 3'h3);
        cyc(15);
        chk(charge_pull_low, 1'b1);
        cyc(5);
        chk({charge_pull_low, dsg_ocp_enable}, 2'h1);
        fl(10'h000, 16'sh0000);
        wr(8'h00, 32'h7430);
        cyc(3);
        chk({discharge_fet_drive, charge_fet_drive}, 2'h0);
        wr(8'h00, 32'h74F0);
        cyc(3);
        chk({discharge_fet_drive, charge_fet_drive}, 2'h0);
        wr(8'h00, 32'h74F8);
        cyc(3);
        chk({discharge_fet_drive, charge_fet_drive}, 2'h3);
        wr(8'h00, 32'h7404);
        fl(10'h001, 16'sh0000);
        chk(discharge_fet_drive, 1'b1);
        wr(8'h00, 32'h7400);
        wr(8'h04, 32'h7FE);
        cyc(3);
        chk(discharge_fet_drive, 1'b1);
        wr(8'h04, 32'h7FF);
        wr(8'h00, 32'h7403);
        fl(10'h001, 16'sh00C8);
        chk(discharge_fet_drive, 1'b1);
        fl(10'h001, 16'sh0032);
        chk(discharge_fet_drive, 1'b0);
        fl(10'h002, -16'sh00C8);
        chk(charge_fet_drive, 1'b1);
        fl(10'h002, -16'sh0032);
        chk(charge_fet_drive, 1'b0);
        wr(8'h00, 32'h7400);
        wr(8'h14, 32'h0);
        fl(10'h000, 16'sh0000);
        wr(8'h18, 32'hFFF);
        fl(10'h001, 16'sh0000);
        chk(alert_n, 1'b1);
        wr(8'h14, 32'hFFF);
        cyc(3);
        chk(alert_n, 1'b0);
        fl(10'h000, 16'sh0000);
        wr(8'h18, 32'hFFF);
        // pwm 4 on, 3 off; charge held steady with a charger present
        wr(8'h0C, 32'h0003_0004);
        wr(8'h10, 32'h0003_0004);
        wr(8'h00, 32'h7700);
        charger_present <= 1'b1;
        cyc(10);
        pw(1'b1);
        chk(n, 70);
        pw(1'b0);
        chk(n, 40);
        charger_present <= 1'b0;
        cyc(10);
        pw(1'b1);
        chk(n, 40);
        for (i = 0; i < 5; i++) begin
            wr(8'h00, 32'h1400 | (i << 13));
            cyc(3);
            chk(regulator_vsel, i);
        end
        pulse(16'h0100);
        rd(8'h1C, 32'h400);
        pulse(16'h0700);
        rd(8'h1C, 32'h0);
        die_hot <= 1'b1;
        cyc(5);
        chk({external_supply_regulator, shutdown_req}, 2'h0);
        die_hot <= 1'b0;
        cyc(5);
        chk(external_supply_regulator, 1'b1);
        wr(8'h00, 32'h7C00);
        die_hot <= 1'b1;
        cyc(5);
        chk({external_supply_regulator, shutdown_req}, 2'h1);
        die_hot <= 1'b0;
        presetn <= 1'b0;
        strap_reg_auto <= 1'b0;
        cyc(3);
        presetn <= 1'b1;
        cyc(3);
        chk({external_supply_regulator, shutdown_req}, 2'h0);
        end_of_test();
    end
endmodule : protection_fet_alert_control_tb_top
